// ### core/pwc_top.sv
// Operation
// - Channel generates pulses only while its enable bit is set.
// - Waveform reaches the pin only while pin output enable is set.
// - Read-only output value bit shows current level; writes ignored.
// - Polarity bit set makes the output active low.
// - Unimplemented control and duty low bits read as zero.
// - Duty high register gives the eight upper duty bits.
// - Duty low bits seven and six give the two lower duty bits.
// - Control bits clear at reset; duty registers not reset.
// - One period timer and period register shared by all channels.
// - Output sets when timer clears unless the new duty is zero, clears at duty match.
// - Duty values double-buffered, loaded at period match.
// - Duty at or above period never clears the output.
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pwc_top #(
  parameter int unsigned NCH = pwc_pkg::NUM_CH
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              arst_n,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // Port latches and pins
  input  wire logic [NCH-1:0]    port_latch,
  output logic [NCH-1:0]         pwm_pin,
  output logic [NCH-1:0]         pwm_level
);
  logic [7:0]  period_r;
  logic [7:0]  tctrl_r;
  logic [7:0]  tcount_r;
  logic [7:0]  tcount_nxt;
  logic [1:0]  sub_r;
  logic [5:0]  pre_r;
  logic [5:0]  pre_nxt;
  logic        flag_r;
  logic        flag_nxt;
  logic [7:0]  ctl_r   [NCH];
  logic [7:0]  dhi_r   [NCH];
  logic [7:0]  dlo_r   [NCH];
  logic [31:0] rd_mux;
  logic        rd_hit;
  pwc_pkg::pwc_tb_t tb;

  wire acc   = psel && penable;
  wire wr    = acc && pwrite;
  wire run   = tctrl_r[pwc_pkg::TCTL_RUN_BIT];
  wire [1:0] ps = tctrl_r[1:0];
  wire [5:0] pre_max = (ps == pwc_pkg::PS_1)  ? 6'h00 :
                       (ps == pwc_pkg::PS_4)  ? 6'h03 :
                       (ps == pwc_pkg::PS_16) ? 6'h0F : 6'h3F;
  wire pre_tick   = run && (pre_r == pre_max);
  wire sub_wrap   = pre_tick && (sub_r == 2'h3);
  wire pmatch     = tcount_r == period_r;
  wire roll       = sub_wrap && pmatch;
  wire ch_space   = paddr >= pwc_pkg::OFF_CH_BASE;
  wire [11:0] ch_off = paddr - pwc_pkg::OFF_CH_BASE;
  wire [7:0]  ch_idx = ch_off[11:4];
  wire [3:0]  ch_reg = ch_off[3:0];
  wire ch_ok      = ch_space && (ch_idx < 8'(NCH));

  // Prescaler selects how often the sub-count advances
  assign pre_nxt = !run ? pre_r : (pre_tick ? 6'h00 : 6'(pre_r + 6'h01));
  assign tcount_nxt = !sub_wrap ? tcount_r :
                      (pmatch ? 8'h00 : 8'(tcount_r + 8'h01));
  // Rollover flag: hardware set wins over software clear
  assign flag_nxt = roll ? 1'b1 :
                    (wr && paddr == pwc_pkg::OFF_FLAG && pwdata[0]) ?
                    1'b0 : flag_r;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_r    <= 6'h00;
      sub_r    <= 2'h0;
      tcount_r <= 8'h00;
      flag_r   <= 1'b0;
    end else begin
      pre_r    <= pre_nxt;
      if (pre_tick) sub_r <= 2'(sub_r + 2'h1);
      tcount_r <= (wr && paddr == pwc_pkg::OFF_TCOUNT) ?
                  pwdata[7:0] : tcount_nxt;
      flag_r   <= flag_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      period_r <= pwc_pkg::PERIOD_RESET;
      tctrl_r  <= pwc_pkg::TCTRL_RESET;
    end else if (wr) begin
      if (paddr == pwc_pkg::OFF_PERIOD) period_r <= pwdata[7:0];
      if (paddr == pwc_pkg::OFF_TCTRL)  tctrl_r  <= pwdata[7:0];
    end
  end

  // Shared time base for every channel; the next value is handed over
  // so that the registered wave changes as the time base reaches duty
  wire [1:0] sub_nxt = pre_tick ? 2'(sub_r + 2'h1) : sub_r;
  assign tb.tbase        = {tcount_nxt, sub_nxt};
  assign tb.period_match = roll;
  assign tb.advance      = pre_tick;

  generate
    for (genvar i = 0; i < NCH; i++) begin : g_ch
      pwc_pkg::pwc_cfg_t cfg;
      wire sel_i = wr && ch_ok && (ch_idx == 8'(i));

      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) ctl_r[i] <= pwc_pkg::CTL_RESET;
        else if (sel_i && ch_reg == pwc_pkg::OFF_CTRL)
          ctl_r[i] <= pwdata[7:0] & pwc_pkg::CTL_WR_MASK;
      end
      // Duty registers keep their value across reset
      always_ff @(posedge core_clk) begin
        if (sel_i && ch_reg == pwc_pkg::OFF_DUTY_HI)
          dhi_r[i] <= pwdata[7:0];
        if (sel_i && ch_reg == pwc_pkg::OFF_DUTY_LO)
          dlo_r[i] <= pwdata[7:0] & pwc_pkg::DLO_MASK;
      end

      assign cfg.en      = ctl_r[i][pwc_pkg::CTL_EN_BIT];
      assign cfg.oe      = ctl_r[i][pwc_pkg::CTL_OE_BIT];
      assign cfg.pol     = ctl_r[i][pwc_pkg::CTL_POL_BIT];
      assign cfg.duty_hi = dhi_r[i];
      assign cfg.duty_lo = dlo_r[i][7:6];

      pwc_chan u_chan (
        .core_clk   (core_clk),
        .arst_n     (arst_n),
        .tb         (tb),
        .period     (period_r),
        .cfg        (cfg),
        .port_latch (port_latch[i]),
        .level      (pwm_level[i]),
        .pin_out    (pwm_pin[i])
      );
    end
  endgenerate

  // Read decode
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    if (paddr == pwc_pkg::OFF_PERIOD) rd_mux[7:0] = period_r;
    else if (paddr == pwc_pkg::OFF_TCTRL) rd_mux[7:0] = tctrl_r;
    else if (paddr == pwc_pkg::OFF_TCOUNT) rd_mux[7:0] = tcount_r;
    else if (paddr == pwc_pkg::OFF_FLAG) rd_mux[0] = flag_r;
    else if (ch_ok && ch_reg == pwc_pkg::OFF_CTRL) begin
      rd_mux[7:0] = ctl_r[ch_idx[1:0]];
      rd_mux[pwc_pkg::CTL_OUT_BIT] = pwm_level[ch_idx[1:0]];
    end
    else if (ch_ok && ch_reg == pwc_pkg::OFF_DUTY_HI)
      rd_mux[7:0] = dhi_r[ch_idx[1:0]];
    else if (ch_ok && ch_reg == pwc_pkg::OFF_DUTY_LO)
      rd_mux[7:0] = dlo_r[ch_idx[1:0]] & pwc_pkg::DLO_MASK;
    else rd_hit = 1'b0;
  end

  assign pready  = 1'b1;
  assign pslverr = acc && !rd_hit;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite) prdata <= rd_mux;
  end

  a_ctl_clear: assert property (@(posedge core_clk) disable iff (!arst_n)
    (ctl_r[0] & ~pwc_pkg::CTL_WR_MASK) == 8'h00)
    else $error("reserved control bits set");
  a_tb_wrap: assert property (@(posedge core_clk) disable iff (!arst_n)
    roll |=> tcount_r == 8'h00) else $error("timer not cleared");
  a_flag_set: assert property (@(posedge core_clk) disable iff (!arst_n)
    roll |=> flag_r) else $error("flag not set");
  a_sub_step: assert property (@(posedge core_clk) disable iff (!arst_n)
    pre_tick |=> sub_r == 2'($past(sub_r) + 2'h1))
    else $error("sub-count stuck");
  c_roll: cover property (@(posedge core_clk) disable iff (!arst_n) roll);
  c_read: cover property (@(posedge core_clk) disable iff (!arst_n)
    acc && !pwrite && rd_hit);
endmodule : pwc_top
`default_nettype wire

// ### core/pwc_pkg.sv
package pwc_pkg;
  localparam int unsigned NUM_CH        = 4;
  localparam int unsigned DUTY_W        = 10;
  // Register word offsets (byte addresses), chosen
  localparam logic [11:0] OFF_PERIOD    = 12'h000;
  localparam logic [11:0] OFF_TCTRL     = 12'h004;
  localparam logic [11:0] OFF_TCOUNT    = 12'h008;
  localparam logic [11:0] OFF_FLAG      = 12'h00C;
  localparam logic [11:0] OFF_CH_BASE   = 12'h010;
  localparam logic [11:0] OFF_CH_STRIDE = 12'h010;
  localparam logic [3:0]  OFF_CTRL      = 4'h0;
  localparam logic [3:0]  OFF_DUTY_HI   = 4'h4;
  localparam logic [3:0]  OFF_DUTY_LO   = 4'h8;
  // Control register fields
  localparam int unsigned CTL_EN_BIT    = 7;
  localparam int unsigned CTL_OE_BIT    = 6;
  localparam int unsigned CTL_OUT_BIT   = 5;
  localparam int unsigned CTL_POL_BIT   = 4;
  localparam int unsigned TCTL_RUN_BIT  = 2;
  localparam logic [7:0]  CTL_RESET     = 8'h00;
  localparam logic [7:0]  CTL_WR_MASK   = 8'hD0;
  localparam logic [7:0]  DLO_MASK      = 8'hC0;
  localparam logic [7:0]  PERIOD_RESET  = 8'hFF;
  localparam logic [7:0]  TCTRL_RESET   = 8'h00;
  localparam logic [1:0]  PS_1          = 2'h0;
  localparam logic [1:0]  PS_4          = 2'h1;
  localparam logic [1:0]  PS_16         = 2'h2;

  typedef struct packed {
    logic [9:0] tbase;
    logic       period_match;
    logic       advance;
  } pwc_tb_t;

  typedef struct packed {
    logic       en;
    logic       oe;
    logic       pol;
    logic [7:0] duty_hi;
    logic [1:0] duty_lo;
  } pwc_cfg_t;
endpackage : pwc_pkg

// ### core/pwc_chan.sv
`timescale 1ns/1ps
`default_nettype none
module pwc_chan (
  // Clock and reset
  input  wire logic          core_clk,
  input  wire logic          arst_n,
  // Shared time base and config
  input  wire pwc_pkg::pwc_tb_t tb,
  input  wire logic [7:0]    period,
  input  wire pwc_pkg::pwc_cfg_t cfg,
  input  wire logic          port_latch,
  // Outputs
  output logic               level,
  output logic               pin_out
);
  logic [9:0] duty_act_r;
  logic       wave_r;
  logic       wave_nxt;
  logic       loaded_r;
  wire  [9:0] duty_wr   = {cfg.duty_hi, cfg.duty_lo};
  wire        full_duty = duty_act_r[9:2] >= period;
  wire        hit       = tb.tbase == duty_act_r;
  wire  [9:0] duty_nxt  = tb.period_match ? duty_wr : duty_act_r;

  // Load buffer at period rollover; duty register contents are not reset
  always_ff @(posedge core_clk) begin
    if (tb.advance) duty_act_r <= duty_nxt;
  end

  always_comb begin
    wave_nxt = wave_r;
    if (!cfg.en) wave_nxt = 1'b0;
    else if (tb.advance) begin
      if (tb.period_match) wave_nxt = (duty_wr != 10'h000);
      else if (hit && !full_duty) wave_nxt = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) wave_r <= 1'b0;
    else wave_r <= wave_nxt;
  end

  // Buffer holds no defined value until its first load after reset
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) loaded_r <= 1'b0;
    else if (tb.advance && tb.period_match) loaded_r <= 1'b1;
  end

  assign level   = wave_r ^ cfg.pol;
  assign pin_out = cfg.oe ? level : port_latch;

  a_disable_low: assert property (@(posedge core_clk) disable iff (!arst_n)
    !cfg.en |=> !wave_r) else $error("wave high while disabled");
  a_pol_map: assert property (@(posedge core_clk) disable iff (!arst_n)
    level == (wave_r != cfg.pol)) else $error("polarity wrong");
  a_pin_route: assert property (@(posedge core_clk) disable iff (!arst_n)
    pin_out == (cfg.oe ? level : port_latch)) else $error("pin mux");
  a_full_duty: assert property (@(posedge core_clk) disable iff (!arst_n)
    cfg.en && wave_r && full_duty && tb.advance && !tb.period_match
    |=> wave_r) else $error("full duty cleared");
  a_dbuf_load: assert property (@(posedge core_clk) disable iff (!arst_n)
    tb.advance && tb.period_match |=> duty_act_r == $past(duty_wr))
    else $error("buffer not loaded");
  a_dbuf_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
    loaded_r && !(tb.advance && tb.period_match) |=> $stable(duty_act_r))
    else $error("buffer changed");
  c_pulse: cover property (@(posedge core_clk) disable iff (!arst_n)
    cfg.en ##1 wave_r ##[1:1000] !wave_r);
  c_pin_on: cover property (@(posedge core_clk) disable iff (!arst_n)
    cfg.oe && cfg.en && wave_r);
endmodule : pwc_chan
`default_nettype wire

// ### dv/pwc_load.sv
`timescale 1ns/1ps
`default_nettype none
module pwc_load (
  // Clock and window clear
  input  wire logic            core_clk,
  input  wire logic            clr,
  // Pins seen by the load
  input  wire logic [3:0]      pin,
  // High cycles seen per pin since clear
  output logic [3:0][7:0]      hi_cnt
);
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < 4; i++) begin
      if (clr) begin
        hi_cnt[i] <= 8'h00;
      end else if (pin[i] === 1'b1) begin
        hi_cnt[i] <= hi_cnt[i] + 8'h01;
      end
    end
  end
endmodule : pwc_load
`default_nettype wire

// ### dv/pwm_channel_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module pwm_channel_control_bench;
  logic            core_clk;
  logic            arst_n;
  logic            psel;
  logic            penable;
  logic            pwrite;
  logic [11:0]     paddr;
  logic [31:0]     pwdata;
  logic            pready;
  logic [31:0]     prdata;
  logic            pslverr;
  logic [3:0]      port_latch;
  logic [3:0]      pwm_pin;
  logic [3:0]      pwm_level;
  logic            clr;
  logic [3:0][7:0] hi_cnt;
  int              n_fail;
  int              checked;

  pwc_top u_pwc_top (.core_clk(core_clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .port_latch(port_latch), .pwm_pin(pwm_pin), .pwm_level(pwm_level));
  pwc_load u_pwc_load (.core_clk(core_clk), .clr(clr), .pin(pwm_pin),
    .hi_cnt(hi_cnt));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic err);
    @(posedge core_clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    q   = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic test_regs;
    logic [31:0] q;
    logic        e;
    apb(1'b0, 12'h010, 32'h0, q, e);
    chk(q, 32'h00000000);
    apb(1'b1, 12'h010, 32'h000000FF, q, e);
    apb(1'b0, 12'h010, 32'h0, q, e);
    chk(q & 32'hFFFFFFDF, 32'h000000D0);
    apb(1'b1, 12'h018, 32'h000000FF, q, e);
    apb(1'b0, 12'h018, 32'h0, q, e);
    chk(q, 32'h000000C0);
    apb(1'b0, 12'hFFC, 32'h0, q, e);
    chk({q[30:0], e}, 32'h00000001);
    $display("test_regs done");
  endtask : test_regs

  task automatic test_wave;
    logic [31:0] q;
    logic        e;
    apb(1'b1, 12'h010, 32'h00, q, e);
    apb(1'b1, 12'h000, 32'h03, q, e);
    apb(1'b1, 12'h014, 32'h02, q, e);
    apb(1'b1, 12'h018, 32'h00, q, e);
    apb(1'b1, 12'h024, 32'h03, q, e);
    apb(1'b1, 12'h044, 32'h01, q, e);
    apb(1'b1, 12'h048, 32'h00, q, e);
    apb(1'b1, 12'h028, 32'h00, q, e);
    apb(1'b1, 12'h034, 32'h00, q, e);
    apb(1'b1, 12'h038, 32'h00, q, e);
    apb(1'b1, 12'h00C, 32'h01, q, e);
    apb(1'b1, 12'h004, 32'h04, q, e);
    apb(1'b1, 12'h010, 32'hC0, q, e);
    apb(1'b1, 12'h020, 32'hC0, q, e);
    apb(1'b1, 12'h030, 32'h00, q, e);
    apb(1'b1, 12'h040, 32'hD0, q, e);
    repeat (40) @(posedge core_clk);
    clr <= 1'b1;
    @(posedge core_clk);
    clr <= 1'b0;
    repeat (16) @(posedge core_clk);
    #1;
    chk(hi_cnt[0], 32'h00000008);
    chk(hi_cnt[1], 32'h00000010);
    chk(hi_cnt[3], 32'h0000000C);
    chk(hi_cnt[2], 32'h00000010);
    chk(pwm_level[2], 1'b0);
    chk(pwm_pin[0], pwm_level[0]);
    apb(1'b0, 12'h00C, 32'h0, q, e);
    chk(q, 32'h00000001);
    $display("test_wave done");
  endtask : test_wave

  task automatic test_presc;
    logic [31:0] q;
    logic        e;
    apb(1'b1, 12'h004, 32'h05, q, e);
    repeat (140) @(posedge core_clk);
    clr <= 1'b1;
    @(posedge core_clk);
    clr <= 1'b0;
    repeat (64) @(posedge core_clk);
    #1;
    chk(hi_cnt[0], 32'h00000020);
    chk(hi_cnt[3], 32'h00000030);
    chk(hi_cnt[1], 32'h00000040);
    $display("test_presc done");
  endtask : test_presc

  task automatic test_reset;
    logic [31:0] q;
    logic        e;
    arst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    apb(1'b0, 12'h010, 32'h0, q, e);
    chk(q, 32'h00000000);
    apb(1'b0, 12'h014, 32'h0, q, e);
    chk(q, 32'h00000002);
    chk(pwm_pin, 4'h4);
    $display("test_reset done");
  endtask : test_reset

  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    n_fail = 0;
    checked = 0;
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    port_latch = 4'h4;
    clr = 1'b0;
    repeat (5) @(posedge core_clk);
    arst_n <= 1'b1;
    test_regs();
    test_wave();
    test_presc();
    test_reset();
    complete_run();
  end

  initial begin
    #20000;
    n_fail++;
    complete_run();
  end
endmodule : pwm_channel_control_bench
`default_nettype wire
